// file: core/ocd_config_top.sv
// converter output rate, word strobe, calibration delay and loop clock configuration
`timescale 1ns/1ps
// Contract
// RULE_01 - output strobe rate field takes effect only when independent divider enable is set
// RULE_02 - channel count codes 1 to 7 give that many inputs, 0 gives eight
// RULE_03 - data rate code 0 is full rate, codes 1 to 9 divide by 2 to 512
// RULE_04 - data rate codes 13, 14 and 15 drive all output data bits zero
// RULE_05 - host must not program data rate codes 10 to 12; outputs undefined
// RULE_06 - strobe rate: 0 and 10-14 no clock, 1-9 divide, 15 full rate
// RULE_07 - a no-clock strobe code leaves the output strobe pins static
// RULE_08 - host should realign data and strobe through the rate register when decimating
// RULE_09 - read data changes on falling serial clock edge if set, else rising
// RULE_10 - word strobe polarity bit set inverts the word strobe
// RULE_11 - randomizer bit set scrambles output data words, clear passes them
// RULE_12 - programmed calibration delay applies only when its enable bit is set
// RULE_13 - calibration start delay grows linearly with the eight-bit delay value
// RULE_14 - duty correction bit set turns on input clock duty correction
// RULE_15 - phase code times 45 degrees shifts the loop output strobe
// RULE_16 - phase selection honoured only with phase shift enabled and no decimation
// RULE_17 - loop strobe output enable clear stops the converter output while loop used
// RULE_18 - loop enable bit set turns on the phase-selecting loop
// RULE_19 - clock buffer enable clear stops internal clock and converter output
// RULE_20 - loop held in reset while its reset bit is 0; host writes 0 then 1
// RULE_21 - host keeps factory bits at their reset values when writing
// RULE_22 - leaving soft reset with the loop enabled resets the loop
// RULE_23 - every register reads back its last write and resets to its default
module ocd_config_top (
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_resetn,
  // serial register port
  input  wire logic                        i_sclk,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_sdi,
  output logic                             o_sdo,
  output logic                             o_sdo_oe,
  // converter data path
  input  wire logic                        i_sample_tick,
  input  wire logic [ocd_pkg::DATA_W-1:0]  i_conv_data,
  output logic      [ocd_pkg::DATA_W-1:0]  o_data,
  output logic                             o_data_valid,
  output logic                             o_word_strobe,
  output logic                             o_strobe_p,
  output logic                             o_strobe_n,
  // device state from outside this block
  input  wire logic                        i_soft_reset_n,
  input  wire logic                        i_phase_shift_enable,
  input  wire logic                        i_decimation_active,
  // channel and calibration
  output logic      [3:0]                  o_active_channels,
  output logic                             o_independent_divider,
  output logic                             o_cal_start,
  // loop and clock path
  output logic                             o_duty_correct_en,
  output logic      [2:0]                  o_phase_select,
  output logic                             o_loop_strobe_en,
  output logic                             o_loop_enable,
  output logic                             o_clk_buffer_en,
  output logic                             o_loop_reset_n
);
  import ocd_pkg::*;

  logic [7:0]        chan_r;
  logic [7:0]        rate_r;
  logic [7:0]        edge_r;
  logic [7:0]        rand_r;
  logic [7:0]        cal_r;
  logic [7:0]        loop_r;
  logic [ADDR_W-1:0] addr;
  logic              wr_en;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              sr_q_r;
  logic              sr_rise;
  logic [3:0]        lrst_cnt_r;
  logic [12:0]       cal_cnt_r;
  logic              cal_busy_r;
  logic [12:0]       cal_delay;
  logic              indep;
  logic [2:0]        chan_code;
  logic [3:0]        data_code;
  logic [3:0]        strb_code;
  logic              data_zero;
  logic              out_allowed;
  logic [4:0]        data_dec;
  logic [4:0]        strb_dec;
  logic              data_tick;
  logic              strb_wave;

  // {run, log2}; codes above 9 stop the divider, code 0 runs it at full rate
  function automatic logic [4:0] div_decode(input logic [3:0] code);
    div_decode = (code <= RATE_DIV_MAX) ? {1'b1, code} : 5'h00;
  endfunction

  function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_CHAN: rd_mux = chan_r;
      ADDR_RATE: rd_mux = rate_r;
      ADDR_EDGE: rd_mux = edge_r;
      ADDR_RAND: rd_mux = rand_r;
      ADDR_CAL:  rd_mux = cal_r;
      ADDR_LOOP: rd_mux = loop_r;
      default:   rd_mux = 8'h00;
    endcase
  endfunction

  // cheap scrambler: the lsb flips all the other bits, so it undoes itself downstream
  function automatic logic [DATA_W-1:0] scramble(input logic [DATA_W-1:0] d);
    scramble = {d[DATA_W-1:1] ^ {(DATA_W-1){d[0]}}, d[0]};
  endfunction

  ocd_spi_slave u_spi (
    .i_clk_sys     (i_clk_sys),
    .i_resetn      (i_resetn),
    .i_sclk        (i_sclk),
    .i_cs_n        (i_cs_n),
    .i_sdi         (i_sdi),
    .o_sdo         (o_sdo),
    .o_sdo_oe      (o_sdo_oe),
    .i_out_on_fall (edge_r[EDGE_BIT]),
    .i_rdata       (rdata),
    .o_addr        (addr),
    .o_wr_en       (wr_en),
    .o_wdata       (wdata)
  );

  // RULE_23 readback mux
  assign rdata = rd_mux(addr);

  // RULE_23 register defaults
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      chan_r <= RST_CHAN;
      rate_r <= RST_RATE;
      edge_r <= RST_EDGE;
      rand_r <= RST_RAND;
      cal_r  <= RST_CAL;
      loop_r <= RST_LOOP;
    end else if (wr_en) begin
      unique case (addr)
        ADDR_CHAN: chan_r <= wdata;
        ADDR_RATE: rate_r <= wdata;
        ADDR_EDGE: edge_r <= wdata;
        ADDR_RAND: rand_r <= wdata;
        ADDR_CAL:  cal_r  <= wdata;
        ADDR_LOOP: loop_r <= wdata;
        default: ;
      endcase
    end
  end

  assign indep     = chan_r[IND_BIT];
  assign chan_code = chan_r[NCH_LSB +: 3];
  assign data_code = rate_r[DRATE_LSB +: 4];
  assign strb_code = rate_r[SRATE_LSB +: 4];
  // RULE_04 zero-data codes
  assign data_zero = data_code >= RATE_ZERO_MIN;

  // RULE_17 RULE_19 output gating
  assign out_allowed = loop_r[CLKEN_BIT] && i_soft_reset_n &&
                       !(loop_r[LEN_BIT] && !loop_r[LSEN_BIT]);

  // RULE_03 data divider; test codes 10-12 stop it, a safe reading of RULE_05
  assign data_dec = data_zero ? {1'b1, RATE_FULL} : div_decode(data_code);

  // RULE_01 RULE_06 strobe source select
  always_comb begin
    if (!indep) begin
      strb_dec = data_dec;
    end else if (strb_code == STRB_FULL) begin
      strb_dec = {1'b1, RATE_FULL};
    end else if (strb_code == STRB_NONE) begin
      strb_dec = 5'h00;
    end else begin
      strb_dec = div_decode(strb_code);
    end
  end

  ocd_rate_gen u_data_rate (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_run     (out_allowed && data_dec[4]),
    .i_log2    (data_dec[3:0]),
    .i_tick    (i_sample_tick),
    .o_tick    (data_tick),
    .o_wave    ()
  );

  ocd_rate_gen u_strb_rate (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_run     (out_allowed && strb_dec[4]),
    .i_log2    (strb_dec[3:0]),
    .i_tick    (i_sample_tick),
    .o_tick    (),
    .o_wave    (strb_wave)
  );

  // RULE_04 RULE_10 RULE_11 output word path
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data        <= '0;
      o_data_valid  <= 1'b0;
      o_word_strobe <= 1'b0;
    end else begin
      o_data_valid  <= data_tick && out_allowed;
      o_word_strobe <= (data_tick && out_allowed) ^ rand_r[POL_BIT];
      if (data_tick && out_allowed) begin
        if (data_zero) begin
          o_data <= '0;
        end else if (rand_r[RAND_BIT]) begin
          o_data <= scramble(i_conv_data);
        end else begin
          o_data <= i_conv_data;
        end
      end
    end
  end

  // RULE_07 static strobe pins
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_strobe_p <= 1'b0;
      o_strobe_n <= 1'b1;
    end else begin
      o_strobe_p <= strb_wave;
      o_strobe_n <= ~strb_wave;
    end
  end

  // RULE_02 channel decode
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_active_channels     <= 4'h1;
      o_independent_divider <= 1'b0;
    end else begin
      o_active_channels     <= (chan_code == NCH_EIGHT_CODE) ? NCH_EIGHT : {1'b0, chan_code};
      o_independent_divider <= indep;
    end
  end

  // RULE_14 RULE_15 RULE_16 RULE_18 RULE_19 loop and clock path controls
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_duty_correct_en <= 1'b0;
      o_phase_select    <= 3'h0;
      o_loop_strobe_en  <= 1'b1;
      o_loop_enable     <= 1'b0;
      o_clk_buffer_en   <= 1'b1;
    end else begin
      o_duty_correct_en <= loop_r[DUTY_BIT];
      o_phase_select    <= (i_phase_shift_enable && !i_decimation_active) ? loop_r[PHASE_LSB +: 3] : 3'h0;
      o_loop_strobe_en  <= loop_r[LSEN_BIT];
      o_loop_enable     <= loop_r[LEN_BIT];
      o_clk_buffer_en   <= loop_r[CLKEN_BIT];
    end
  end

  // soft reset is a plain level from the mode register outside this block
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sr_q_r <= 1'b1;
    end else begin
      sr_q_r <= i_soft_reset_n;
    end
  end

  assign sr_rise = i_soft_reset_n && !sr_q_r;

  // RULE_20 RULE_22 loop reset: the bit holds it, a soft reset exit with the loop enabled pulses it
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      lrst_cnt_r     <= 4'h0;
      o_loop_reset_n <= 1'b0;
    end else begin
      if (sr_rise && loop_r[LEN_BIT]) begin
        lrst_cnt_r <= LOOP_RST_CYC;
      end else if (lrst_cnt_r != 4'h0) begin
        lrst_cnt_r <= lrst_cnt_r - 4'h1;
      end
      o_loop_reset_n <= loop_r[LRST_BIT] && (lrst_cnt_r == 4'h0) && !(sr_rise && loop_r[LEN_BIT]);
    end
  end

  // RULE_12 RULE_13 linear start delay
  assign cal_delay = rand_r[CALEN_BIT] ? CAL_BASE_CYC + 13'(cal_r) * CAL_STEP_CYC : CAL_BASE_CYC;

  // a new soft reset exit restarts the wait rather than stacking a second start
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cal_cnt_r   <= 13'h0000;
      cal_busy_r  <= 1'b0;
      o_cal_start <= 1'b0;
    end else begin
      o_cal_start <= 1'b0;
      if (sr_rise) begin
        cal_cnt_r  <= cal_delay;
        cal_busy_r <= 1'b1;
      end else if (cal_busy_r) begin
        if (cal_cnt_r == 13'h0000) begin
          cal_busy_r  <= 1'b0;
          o_cal_start <= 1'b1;
        end else begin
          cal_cnt_r <= cal_cnt_r - 13'h0001;
        end
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  AST_CHAN_DECODE: assert property ( // RULE_02
    $stable(chan_code) |-> o_active_channels == ((chan_code == 3'h0) ? 4'h8 : {1'b0, chan_code}))
    else $error("channel count does not match its code");

  AST_DATA_ZERO: assert property ( // RULE_04
    (o_data_valid && $past(data_zero)) |-> (o_data == '0))
    else $error("zero-data code let nonzero data out");

  AST_STRB_STOP: assert property ( // RULE_07
    (indep && (strb_code == STRB_NONE))[*3] |-> (!o_strobe_p && o_strobe_n))
    else $error("strobe pins toggling under a no-clock code");

  AST_WORD_POL: assert property ( // RULE_10
    o_word_strobe == (o_data_valid ^ $past(rand_r[POL_BIT])))
    else $error("word strobe polarity wrong");

  AST_PHASE_GATE: assert property ( // RULE_16
    (!i_phase_shift_enable || i_decimation_active) |=> (o_phase_select == 3'h0))
    else $error("phase select honoured while gated off");

  AST_CLK_OFF: assert property ( // RULE_19
    !loop_r[CLKEN_BIT] |=> !o_data_valid)
    else $error("data produced with the clock buffer off");

  AST_LOOP_HOLD: assert property ( // RULE_20
    !loop_r[LRST_BIT] |=> !o_loop_reset_n)
    else $error("loop released while its reset bit is clear");

  AST_LOOP_PULSE: assert property ( // RULE_22
    (sr_rise && loop_r[LEN_BIT]) |=> !o_loop_reset_n[*8])
    else $error("loop not reset on soft reset exit");

  AST_CAL_MIN: assert property ( // RULE_12
    (sr_rise && !rand_r[CALEN_BIT]) ##1 (!sr_rise)[*8] ##1 (!sr_rise)[*8] ##1 !sr_rise |=> o_cal_start)
    else $error("calibration start missed the minimum delay");

  COV_WRITE: cover property (wr_en && (addr == ADDR_LOOP));
  COV_DIV512: cover property (o_data_valid && (data_code == RATE_DIV_MAX));
  COV_CAL: cover property (o_cal_start);

endmodule // ocd_config_top

// file: shared/ocd_pkg.sv
// constants for the converter output clock, loop and rate configuration block
package ocd_pkg;

  // serial frame: r/w bit, two count bits, 13-bit address, then one data byte
  localparam int unsigned ADDR_W      = 13;
  localparam int unsigned DATA_W      = 16;
  localparam logic [4:0]  HDR_LAST    = 5'h0f;
  localparam logic [4:0]  FRAME_LAST  = 5'h17;
  localparam logic [4:0]  FRAME_BITS  = 5'h18;

  // register offsets
  localparam logic [12:0] ADDR_CHAN   = 13'h0001;
  localparam logic [12:0] ADDR_RATE   = 13'h0002;
  localparam logic [12:0] ADDR_EDGE   = 13'h0004;
  localparam logic [12:0] ADDR_RAND   = 13'h0007;
  localparam logic [12:0] ADDR_CAL    = 13'h001e;
  localparam logic [12:0] ADDR_LOOP   = 13'h0052;

  // reset values, factory bits included
  localparam logic [7:0]  RST_CHAN    = 8'h0f;
  localparam logic [7:0]  RST_RATE    = 8'h00;
  localparam logic [7:0]  RST_EDGE    = 8'h9f;
  localparam logic [7:0]  RST_RAND    = 8'h62;
  localparam logic [7:0]  RST_CAL     = 8'h80;
  localparam logic [7:0]  RST_LOOP    = 8'h0a;

  // field positions
  localparam int unsigned IND_BIT     = 7;
  localparam int unsigned NCH_LSB     = 3;
  localparam int unsigned DRATE_LSB   = 4;
  localparam int unsigned SRATE_LSB   = 0;
  localparam int unsigned EDGE_BIT    = 7;
  localparam int unsigned POL_BIT     = 7;
  localparam int unsigned CALEN_BIT   = 6;
  localparam int unsigned RAND_BIT    = 0;
  localparam int unsigned DUTY_BIT    = 7;
  localparam int unsigned PHASE_LSB   = 4;
  localparam int unsigned LSEN_BIT    = 3;
  localparam int unsigned LEN_BIT     = 2;
  localparam int unsigned CLKEN_BIT   = 1;
  localparam int unsigned LRST_BIT    = 0;

  // rate codes
  localparam logic [3:0]  RATE_FULL   = 4'h0;
  localparam logic [3:0]  RATE_DIV_MAX = 4'h9;
  localparam logic [3:0]  RATE_ZERO_MIN = 4'hd;
  localparam logic [3:0]  STRB_FULL   = 4'hf;
  localparam logic [3:0]  STRB_NONE   = 4'h0;
  localparam logic [2:0]  NCH_EIGHT_CODE = 3'h0;
  localparam logic [3:0]  NCH_EIGHT   = 4'h8;

  // timing
  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned LOOP_RST_NS  = 100;
  localparam logic [3:0]  LOOP_RST_CYC = 4'((LOOP_RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] CAL_BASE_CYC = 13'h0010;
  localparam logic [12:0] CAL_STEP_CYC = 13'h0010;

endpackage

// file: core/ocd_rate_gen.sv
// divides the sample tick by a power of two and makes a word tick and a strobe wave
`timescale 1ns/1ps
module ocd_rate_gen (
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_resetn,
  // control
  input  wire logic       i_run,
  input  wire logic [3:0] i_log2,
  input  wire logic       i_tick,
  // results
  output logic            o_tick,
  output logic            o_wave
);

  logic [8:0] cnt_r;
  logic [8:0] lim;

  assign lim = 9'((10'h001 << i_log2) - 10'h001);

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 9'h000;
    end else if (!i_run) begin
      cnt_r <= 9'h000;
    end else if (i_tick) begin
      cnt_r <= (cnt_r >= lim) ? 9'h000 : cnt_r + 9'h001;
    end
  end

  // the wave toggles once per output word, so it idles low when stopped
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tick <= 1'b0;
      o_wave <= 1'b0;
    end else begin
      o_tick <= i_run && i_tick && (cnt_r >= lim);
      if (!i_run) begin
        o_wave <= 1'b0;
      end else if (i_tick && (cnt_r >= lim)) begin
        o_wave <= ~o_wave;
      end
    end
  end

endmodule // ocd_rate_gen

// file: core/ocd_spi_slave.sv
// serial register port: 16-bit header, one data byte, read data on a chosen edge
`timescale 1ns/1ps
module ocd_spi_slave (
  // clock and reset
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_resetn,
  // serial pins
  input  wire logic                        i_sclk,
  input  wire logic                        i_cs_n,
  input  wire logic                        i_sdi,
  output logic                             o_sdo,
  output logic                             o_sdo_oe,
  // register side
  input  wire logic                        i_out_on_fall,
  input  wire logic [7:0]                  i_rdata,
  output logic      [ocd_pkg::ADDR_W-1:0]  o_addr,
  output logic                             o_wr_en,
  output logic      [7:0]                  o_wdata
);
  import ocd_pkg::*;

  logic       sclk_q_r;
  logic [4:0] cnt_r;
  logic [14:0] sh_r;
  logic       rd_r;
  logic       data_ph_r;
  logic       load_r;
  logic [7:0] tx_r;
  logic       rise;
  logic       fall;
  logic       out_edge;

  assign rise     = i_sclk && !sclk_q_r;
  assign fall     = !i_sclk && sclk_q_r;
  // RULE_09 edge select
  assign out_edge = i_out_on_fall ? fall : rise;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q_r <= 1'b0;
    end else begin
      sclk_q_r <= i_sclk;
    end
  end

  // bits past the frame are ignored; the counter parks at the frame length
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r     <= 5'h00;
      sh_r      <= 15'h0000;
      rd_r      <= 1'b0;
      data_ph_r <= 1'b0;
      load_r    <= 1'b0;
      o_addr    <= '0;
      o_wr_en   <= 1'b0;
      o_wdata   <= 8'h00;
    end else begin
      load_r  <= 1'b0;
      o_wr_en <= 1'b0;
      if (i_cs_n) begin
        cnt_r     <= 5'h00;
        rd_r      <= 1'b0;
        data_ph_r <= 1'b0;
      end else if (rise && (cnt_r != FRAME_BITS)) begin
        sh_r  <= {sh_r[13:0], i_sdi};
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r == HDR_LAST) begin
          o_addr    <= {sh_r[11:0], i_sdi};
          rd_r      <= sh_r[14];
          data_ph_r <= 1'b1;
          load_r    <= 1'b1;
        end
        if ((cnt_r == FRAME_LAST) && !rd_r) begin
          o_wr_en <= 1'b1;
          o_wdata <= {sh_r[6:0], i_sdi};
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_r     <= 8'h00;
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (i_cs_n) begin
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (load_r) begin
      tx_r <= i_rdata;
    // RULE_09 shift on edge
    end else if (out_edge && data_ph_r && rd_r) begin
      o_sdo    <= tx_r[7];
      tx_r     <= {tx_r[6:0], 1'b0};
      o_sdo_oe <= 1'b1;
    end
  end

  AST_SDO_EDGE: assert property (@(posedge i_clk_sys) disable iff (!i_resetn) // RULE_09
    (!i_cs_n && $changed(o_sdo)) |-> $past(out_edge))
    else $error("read data changed away from the selected clock edge");

  COV_READ: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_sdo_oe && fall);

endmodule // ocd_spi_slave

// file: tb/ocd_spi_host.sv
// serial host model that frames single-byte register reads and writes
`timescale 1ns/1ps
module ocd_spi_host (
  // clock
  input  wire logic i_clk_sys,
  // serial pins
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge i_clk_sys);
  endtask

  // on_fall picks where read bits are taken: end of low phase, else end of high phase
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, input logic on_fall,
                      output logic [7:0] rdat);
    logic [23:0] frm;
    frm  = {rd, 2'b00, a, wd};
    rdat = 8'h00;
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      o_sdi <= frm[i];
      half();
      if (on_fall && i < 8) rdat[i] = i_sdo_oe ? i_sdo : ~i_sdo;
      o_sclk <= 1'b1;
      half();
      if (!on_fall && i < 8) rdat[i] = i_sdo_oe ? i_sdo : ~i_sdo;
      o_sclk <= 1'b0;
    end
    half();
    o_cs_n <= 1'b1;
    // a released line shows the inverse so a stale sample cannot pass
    o_sdi  <= ~frm[0];
    half();
  endtask
endmodule // ocd_spi_host

// file: tb/ocd_config_top_tb.sv
// self-checking bench for the rate, strobe, calibration and loop configuration block
`timescale 1ns/1ps
module ocd_config_top_tb;
  import ocd_pkg::*;
  logic              clk, rst_n, sclk, cs_n, sdi, sdo, oe, tick, valid, wstrb, sp, sn, sr_n, phen, decim;
  logic              cal, indep, duty, lsen, len, cbe, lrst, mon, pol, sp_q;
  logic [DATA_W-1:0] conv, dout, exp_d;
  logic [3:0]        chans;
  logic [2:0]        phase;
  logic [7:0]        rd;
  int                fail_count, checks, nval, nstr, cyc;
  localparam logic [12:0] AD[7] = '{ADDR_CHAN, ADDR_RATE, ADDR_EDGE, ADDR_RAND, ADDR_CAL, ADDR_LOOP, 13'h0003};
  localparam logic [7:0]  RV[7] = '{RST_CHAN, RST_RATE, RST_EDGE, RST_RAND, RST_CAL, RST_LOOP, 8'h00};

  always #5 clk = ~clk;

  ocd_config_top uut (.i_clk_sys(clk), .i_resetn(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe(oe), .i_sample_tick(tick), .i_conv_data(conv), .o_data(dout),
    .o_data_valid(valid), .o_word_strobe(wstrb), .o_strobe_p(sp), .o_strobe_n(sn),
    .i_soft_reset_n(sr_n), .i_phase_shift_enable(phen), .i_decimation_active(decim),
    .o_active_channels(chans), .o_independent_divider(indep), .o_cal_start(cal),
    .o_duty_correct_en(duty), .o_phase_select(phase), .o_loop_strobe_en(lsen),
    .o_loop_enable(len), .o_clk_buffer_en(cbe), .o_loop_reset_n(lrst));
  ocd_spi_host host (.i_clk_sys(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo), .i_sdo_oe(oe));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // words and strobe edges are counted only while a run is open
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    sp_q <= sp;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
    if (mon && valid) nval++;
    if (mon && valid) check("o_data", dout, exp_d);
    if (mon && sp !== sp_q) nstr++;
    if (mon) check("o_word_strobe", wstrb, valid ^ pol);
  end

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 1'b1, rd);
  endtask

  task automatic rchk(input logic [12:0] a, input logic [7:0] e, input logic on_fall);
    host.xfer(1'b1, a, 8'h00, on_fall, rd);
    check("read", rd, e);
  endtask

  // a soft reset pulse first, so the divider starts from a cleared count
  task automatic run(input int n);
    @(posedge clk);
    sr_n <= 1'b0;
    repeat (2) @(posedge clk);
    sr_n <= 1'b1;
    nval = 0;
    nstr = 0;
    mon  <= 1'b1;
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    mon <= 1'b0;
    @(posedge clk);
  endtask

  task automatic meas(output int dc, output int dl);
    @(posedge clk);
    sr_n <= 1'b0;
    repeat (2) @(posedge clk);
    sr_n <= 1'b1;
    dc = 0;
    dl = 0;
    for (int k = 1; k <= 80; k++) begin
      @(posedge clk);
      #1;
      if (cal && dc == 0) dc = k;
      if (!lrst) dl++;
    end
  endtask

  task automatic t_reset();
    @(posedge clk);
    #1;
    check("chans", chans, 4'h1);
    check("lrst", lrst, 1'b0);
    check("loop", {duty, phase, lsen, len, cbe, indep}, 8'h0a);
    check("strobe", {sp, sn}, 2'b01);
    for (int i = 0; i < 7; i++) rchk(AD[i], RV[i], 1'b1);
  endtask

  task automatic t_channels();
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CHAN, {c[0], 1'b0, 3'(c), 3'b111});
      check("chans", chans, (c == 0) ? 4'h8 : 4'(c));
      check("indep", indep, c[0]);
    end
    rchk(ADDR_CHAN, 8'hbf, 1'b1);
  endtask

  task automatic t_cal();
    int dc, dl;
    wr(ADDR_LOOP, 8'h0f);
    check("lrst", lrst, 1'b1);
    wr(ADDR_CAL, 8'h01);
    meas(dc, dl);
    check("cal", dc, 34);
    check("lrst_low", dl, 11);
    wr(ADDR_RAND, 8'h22);
    meas(dc, dl);
    check("cal_off", dc, 18);
    wr(ADDR_CAL, 8'h00);
    wr(ADDR_RAND, 8'h62);
    wr(ADDR_LOOP, 8'h0b);
    meas(dc, dl);
    check("cal_min", dc, 18);
    check("lrst_off", dl, 0);
  endtask

  task automatic t_loop();
    wr(ADDR_CHAN, 8'h8f);
    wr(ADDR_RATE, 8'h0f);
    wr(ADDR_LOOP, 8'h08);
    run(16);
    check("no_clk", {cbe, nval[7:0]}, 9'h000);
    wr(ADDR_LOOP, 8'h06);
    run(16);
    check("no_lclk", {len, lsen, nval[7:0]}, 10'h200);
    wr(ADDR_LOOP, 8'hde);
    check("duty_ph", {duty, phase, lrst}, 5'h1a);
    decim <= 1'b1;
    repeat (4) @(posedge clk);
    check("ph_dec", phase, 3'h0);
    decim <= 1'b0;
    phen  <= 1'b0;
    repeat (4) @(posedge clk);
    check("ph_off", phase, 3'h0);
    phen <= 1'b1;
    wr(ADDR_LOOP, 8'h0b);
  endtask

  // host keeps factory bits at defaults and never programs the test rate codes
  task automatic t_rates();
    logic [7:0] rt[8] = '{8'h00, 8'h30, 8'h90, 8'h0f, 8'h01, 8'h00, 8'h0e, 8'h29};
    logic [0:7] ind = 8'b00011111;
    int ev[8] = '{512, 64, 1, 512, 512, 512, 512, 128};
    int es[8] = '{512, 64, 1, 512, 256, 0, 0, 1};
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CHAN, {ind[i], 7'h0f});
      wr(ADDR_RATE, rt[i]);
      run(512);
      check("words", nval, ev[i]);
      check("strobes", nstr, es[i]);
    end
  endtask

  task automatic t_data();
    exp_d = 16'h0000;
    wr(ADDR_RATE, 8'hdf);
    run(16);
    check("zero_words", nval, 16);
    wr(ADDR_RATE, 8'h0f);
    wr(ADDR_RAND, 8'h63);
    conv  <= 16'h1235;
    exp_d = 16'hedcb;
    run(16);
    check("rand_words", nval, 16);
    wr(ADDR_RAND, 8'he2);
    pol   = 1'b1;
    exp_d = 16'h1235;
    run(16);
    check("pol_words", nval, 16);
  endtask

  task automatic t_edge();
    wr(ADDR_EDGE, 8'h1f);
    rchk(ADDR_EDGE, 8'h1f, 1'b0);
    wr(ADDR_EDGE, 8'h9f);
    rchk(ADDR_EDGE, 8'h9f, 1'b1);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    tick = 1'b0;
    conv = 16'h1234;
    exp_d = 16'h1234;
    sr_n = 1'b1;
    phen = 1'b1;
    decim = 1'b0;
    mon = 1'b0;
    pol = 1'b0;
    sp_q = 1'b0;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_channels();
    t_cal();
    t_loop();
    t_rates();
    t_data();
    t_edge();
    final_report();
  end
endmodule // ocd_config_top_tb
